/* File: link_irq_event.sv */
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
// Contract
// - Source edge or set write sets bit
// - Only clear-address one clears bit
// - Event read returns event AND mask
// - Bits 31 and 28 read zero
// - Enabled GPIO pin interrupts set bit 30
// - Bit 29 is software only
// - Late-ack conditions set bit 27 when enabled
// - PHY byte received sets 26, readable
// - Cycle master overrun past 125us sets 25
// - Overrun clears cycle master enable
// - Fatal subunit stop sets bit 24
// - Fatal bit blocks offending contexts' events
module link_irq_event
   import irq_event_pkg::*;
#(
   parameter int CYCLE_LIMIT = CYCLE_LIMIT_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic gpio2_pin,
   input wire logic gpio3_pin,
   input wire logic rx_fifo_pending,
   input wire logic phys_resp_busy,
   input wire logic ack_tardy_sent,
   input wire logic phy_byte_valid,
   input wire logic [7:0] phy_byte,
   input wire logic cycle_start_tx,
   input wire logic subaction_gap_end,
   input wire logic context_dead,
   input wire logic [31:0] context_event_block,
   output logic irq
);

   // ********************************
   // Pin synchronisers
   // ********************************
   // Both pins share one synchroniser; bit 0 is gpio2, bit 1 is gpio3
   logic [1:0] gpio_meta_q;
   logic [1:0] gpio_sync_q;
   logic [1:0] gpio_old_q;
   logic [1:0] gpio_rise;

   // First stage may go metastable; only the second stage reads it
   always_ff @(posedge clk) begin
      if (rst) begin
         gpio_meta_q <= 2'h0;
      end else begin
         gpio_meta_q <= {gpio3_pin, gpio2_pin};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         gpio_sync_q <= 2'h0;
      end else begin
         gpio_sync_q <= gpio_meta_q;
      end
   end

   // Resets to the idle low level, so no false edge follows reset
   always_ff @(posedge clk) begin
      if (rst) begin
         gpio_old_q <= 2'h0;
      end else begin
         gpio_old_q <= gpio_sync_q;
      end
   end

   assign gpio_rise = gpio_sync_q & ~gpio_old_q;

   // ********************************
   // APB decode
   // ********************************
   logic access;
   logic wr;
   logic known;
   assign access = psel && penable && pready;
   assign wr = access && pwrite;
   assign known = (paddr == ADDR_EVENT_SET) || (paddr == ADDR_EVENT_CLEAR)
      || (paddr == ADDR_MASK_SET) || (paddr == ADDR_MASK_CLEAR)
      || (paddr == ADDR_CONTROL) || (paddr == ADDR_PHY_DATA)
      || (paddr == ADDR_RAW_EVENT);

   // Ready one cycle into the access phase: two-cycle access phase total
   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   // ********************************
   // Control register
   // ********************************
   logic [31:0] ctl_q;
   logic [31:0] ctl_d;
   logic overrun_pulse;
   logic ctl_wr;

   assign ctl_wr = wr && (paddr == ADDR_CONTROL);

   // Overrun beats a same-cycle write so cycle master cannot stay on
   always_comb begin
      ctl_d = ctl_q;
      if (ctl_wr) begin
         ctl_d = pwdata & CTL_IMPL;
      end
      if (overrun_pulse) begin
         ctl_d[CTL_CYCLE_MASTER] = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_q <= RESET_ZERO;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   // ********************************
   // Hardware event sources
   // ********************************
   logic gpio_hit;
   logic tardy_hit;
   logic tardy_lvl_q;
   logic [7:0] phy_byte_q;
   logic [CNT_W-1:0] cyc_cnt_q;
   logic cyc_run_q;

   assign gpio_hit = (ctl_q[CTL_GPIO2_EN] && gpio_rise[0])
      || (ctl_q[CTL_GPIO3_EN] && gpio_rise[1]);

   logic tardy_any;
   // Sources are levels; only the rise of their OR counts as one event
   assign tardy_any = rx_fifo_pending || phys_resp_busy || ack_tardy_sent;

   always_ff @(posedge clk) begin
      if (rst) begin
         tardy_lvl_q <= 1'b0;
      end else begin
         tardy_lvl_q <= tardy_any;
      end
   end
   assign tardy_hit = ctl_q[CTL_LATE_ACK_EN] && tardy_any && !tardy_lvl_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         phy_byte_q <= 8'h00;
      end else if (phy_byte_valid) begin
         phy_byte_q <= phy_byte;
      end
   end

   logic cyc_stop;
   assign cyc_stop = !ctl_q[CTL_CYCLE_MASTER] || subaction_gap_end || overrun_pulse;

   // Run flag: high from cycle start send until subaction gap end, overrun or cycle master off
   always_ff @(posedge clk) begin
      if (rst) begin
         cyc_run_q <= 1'b0;
      end else if (cyc_stop) begin
         cyc_run_q <= 1'b0;
      end else if (cycle_start_tx) begin
         cyc_run_q <= 1'b1;
      end
   end

   // Restarted by each cycle start so it measures the newest one
   always_ff @(posedge clk) begin
      if (rst) begin
         cyc_cnt_q <= '0;
      end else if (cyc_stop || cycle_start_tx) begin
         cyc_cnt_q <= '0;
      end else if (cyc_run_q) begin
         cyc_cnt_q <= cyc_cnt_q + CNT_W'(1);
      end
   end
   assign overrun_pulse = cyc_run_q && ctl_q[CTL_CYCLE_MASTER]
      && !subaction_gap_end && (cyc_cnt_q == CNT_W'(CYCLE_LIMIT));

   // ********************************
   // Event and mask registers
   // ********************************
   logic [31:0] event_q;
   logic [31:0] mask_q;
   logic [31:0] hw_set;
   logic [31:0] sw_set;
   logic [31:0] sw_clr;
   logic [31:0] blocked;

   always_comb begin
      hw_set = RESET_ZERO;
      hw_set[BIT_GPIO] = gpio_hit;
      hw_set[BIT_TARDY] = tardy_hit;
      hw_set[BIT_PHYREG] = phy_byte_valid;
      hw_set[BIT_OVERRUN] = overrun_pulse;
      hw_set[BIT_FATAL] = context_dead;
   end

   // Software bit 29 never gets a hardware source
   assign blocked = event_q[BIT_FATAL] ? context_event_block : RESET_ZERO;
   assign sw_set = (wr && paddr == ADDR_EVENT_SET) ? pwdata : RESET_ZERO;
   assign sw_clr = (wr && paddr == ADDR_EVENT_CLEAR) ? pwdata : RESET_ZERO;

   // Set wins over a same-cycle clear so no event is lost
   logic [31:0] event_d;

   always_comb begin
      event_d = (event_q & ~sw_clr) | (hw_set & ~blocked) | sw_set;
      event_d = event_d & EVENT_IMPL;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         event_q <= RESET_ZERO;
      end else begin
         event_q <= event_d;
      end
   end

   // ********************************
   // Mask register
   // ********************************

   logic [31:0] mask_d;

   always_comb begin
      mask_d = mask_q;
      if (wr && paddr == ADDR_MASK_SET) begin
         mask_d = (mask_q | pwdata) & EVENT_IMPL;
      end else if (wr && paddr == ADDR_MASK_CLEAR) begin
         mask_d = mask_q & ~pwdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mask_q <= RESET_ZERO;
      end else begin
         mask_q <= mask_d;
      end
   end

   // ********************************
   // Read data and interrupt
   // ********************************
   logic [31:0] rdata_d;
   logic [31:0] phy_word;

   assign phy_word = 32'(phy_byte_q) << PHY_LSB;

   always_comb begin
      rdata_d = RESET_ZERO;
      case (paddr)
         ADDR_EVENT_SET, ADDR_EVENT_CLEAR: rdata_d = event_q & mask_q;
         ADDR_MASK_SET, ADDR_MASK_CLEAR: rdata_d = mask_q;
         ADDR_CONTROL: rdata_d = ctl_q;
         ADDR_PHY_DATA: rdata_d = phy_word;
         ADDR_RAW_EVENT: rdata_d = event_q;
         default: rdata_d = RESET_ZERO;
      endcase
   end

   logic first_access;
   // Answer is loaded in the first access cycle and stands with pready
   assign first_access = psel && penable && !pready;

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= RESET_ZERO;
      end else begin
         prdata <= (first_access && !pwrite) ? rdata_d : RESET_ZERO;
      end
   end

   // Unmapped reads return zero and unmapped writes are dropped
   always_ff @(posedge clk) begin
      if (rst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= first_access && !known;
      end
   end

   // Registered: follows event and mask one cycle late
   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(event_q & mask_q);
      end
   end

endmodule : link_irq_event

/* File: irq_event_pkg.sv */
package irq_event_pkg;
   localparam logic [11:0] ADDR_EVENT_SET = 12'h080;
   localparam logic [11:0] ADDR_EVENT_CLEAR = 12'h084;
   localparam logic [11:0] ADDR_MASK_SET = 12'h088;
   localparam logic [11:0] ADDR_MASK_CLEAR = 12'h08C;
   localparam logic [11:0] ADDR_CONTROL = 12'h090;
   localparam logic [11:0] ADDR_PHY_DATA = 12'h094;
   localparam logic [11:0] ADDR_RAW_EVENT = 12'h098;
   // Event bit positions
   localparam int BIT_GPIO = 30;
   localparam int BIT_SOFT = 29;
   localparam int BIT_TARDY = 27;
   localparam int BIT_PHYREG = 26;
   localparam int BIT_OVERRUN = 25;
   localparam int BIT_FATAL = 24;
   // Implemented event bits; 31 and 28 stay zero
   localparam logic [31:0] EVENT_IMPL = 32'h6F00_0000;
   // Control register fields
   localparam int CTL_GPIO3_EN = 31;
   localparam int CTL_LATE_ACK_EN = 29;
   localparam int CTL_GPIO2_EN = 23;
   localparam int CTL_CYCLE_MASTER = 21;
   localparam logic [31:0] CTL_IMPL = 32'hA0A0_0000;
   localparam int PHY_LSB = 16;
   localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
   localparam logic [31:0] DATA_ONE = 32'h0000_0001;
   // Cycle overrun limit
   localparam int CYCLE_LIMIT_NS = 125000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CYCLE_LIMIT_CYC = CYCLE_LIMIT_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 13;
endpackage : irq_event_pkg

/* File: link_irq_event_props.sv */
`timescale 1ns/1ps
module link_irq_event_props
   import irq_event_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq
);
   // ********
   // Bus checks
   // ********
   logic map;
   logic evt;
   assign map = paddr >= ADDR_EVENT_SET && paddr <= ADDR_RAW_EVENT && paddr[1:0] == 2'b00;
   assign evt = paddr == ADDR_EVENT_SET || paddr == ADDR_EVENT_CLEAR || paddr == ADDR_RAW_EVENT;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_rdy; psel && penable && !$past(penable) |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready late");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("pready too long");
   property p_idle; !pready |-> prdata == RESET_ZERO; endproperty
   a_idle: assert property (p_idle) else $error("prdata not idle");
   property p_err; pslverr |-> pready && !map; endproperty
   a_err: assert property (p_err) else $error("stray pslverr");
   property p_unmap; pready && !map |-> pslverr && prdata == RESET_ZERO; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped answer");
   property p_rsvd; pready && !pwrite && evt |-> !prdata[31] && !prdata[28]; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_ctl; pready && !pwrite && paddr == ADDR_CONTROL |-> !(prdata & ~CTL_IMPL); endproperty
   a_ctl: assert property (p_ctl) else $error("control bits");
   // Only an event-clear or mask-clear write may drop the request
   property p_fall;
      $fell(irq) |-> $past(pready && pwrite
         && (paddr == ADDR_EVENT_CLEAR || paddr == ADDR_MASK_CLEAR), 2);
   endproperty
   a_fall: assert property (p_fall) else $error("irq fell");
   c_rise: cover property ($rose(irq));
   c_fall: cover property ($fell(irq));
   c_err: cover property (pslverr);
endmodule : link_irq_event_props
bind link_irq_event link_irq_event_props link_irq_event_props_inst (.clk(clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq(irq));

/* File: tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
$display("Error %0t: got %h exp %h", $time, a, b); end end
module tb
   import irq_event_pkg::*;
;
   // ********
   // Stimulus and checks
   // ********
   // Short limit keeps overrun runs brief
   localparam int LIM = 20;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er, pready, pslverr, irq;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, cblk = 32'h0000_0000, seed = 32'h0000_F4AC, rd, prdata;
   logic [7:0] pbyte = 8'h00;
   logic [8:0] src = 9'h000;
   int error_cnt = 0, cmp_count = 0, cyc = 0;
   link_irq_event #(.CYCLE_LIMIT(LIM)) link_irq_event_inst (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .gpio2_pin(src[0]), .gpio3_pin(src[1]),
      .rx_fifo_pending(src[2]), .phys_resp_busy(src[3]), .ack_tardy_sent(src[4]),
      .phy_byte_valid(src[5]), .phy_byte(pbyte), .cycle_start_tx(src[7]),
      .subaction_gap_end(src[8]), .context_dead(src[6]), .context_event_block(cblk), .irq(irq));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [31:0] src_bit(input int i);
      return DATA_ONE << (i < 2 ? BIT_GPIO : i < 5 ? BIT_TARDY : i == 5 ? BIT_PHYREG : BIT_FATAL);
   endfunction : src_bit
   task automatic finish_test();
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, RESET_ZERO);
      `CHK(rd, e)
   endtask : rchk
   task automatic pulse(input int i);
      @(posedge clk);
      src[i] <= 1'b1;
      @(posedge clk);
      src[i] <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : pulse
   initial forever #20 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         error_cnt++;
         finish_test();
      end
   end
   initial begin
      logic [31:0] v, m, c, ev;
      ev = RESET_ZERO;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rchk(ADDR_RAW_EVENT, RESET_ZERO);
      // Sources stay idle here so the raw value is exact
      for (int k = 0; k < 8; k++) begin
         v = k == 0 ? 32'hFFFF_FFFF : rnd();
         m = rnd();
         c = k == 1 ? RESET_ZERO : rnd();
         ev = (ev | v) & EVENT_IMPL & ~c;
         apb(1'b1, ADDR_EVENT_SET, v);
         apb(1'b1, ADDR_EVENT_CLEAR, c);
         apb(1'b1, ADDR_EVENT_SET, RESET_ZERO);
         rchk(ADDR_RAW_EVENT, ev);
         apb(1'b1, ADDR_MASK_CLEAR, 32'hFFFF_FFFF);
         apb(1'b1, ADDR_MASK_SET, m);
         rchk(ADDR_EVENT_SET, ev & m);
         rchk(ADDR_EVENT_CLEAR, ev & m);
         rchk(ADDR_MASK_CLEAR, m & EVENT_IMPL);
         `CHK(irq, |(ev & m))
      end
      $display("register test done");
      apb(1'b1, ADDR_EVENT_CLEAR, 32'hFFFF_FFFF);
      apb(1'b1, ADDR_MASK_SET, 32'hFFFF_FFFF);
      `CHK(irq, 1'b0)
      apb(1'b1, ADDR_CONTROL, CTL_IMPL);
      for (int i = 0; i < 7; i++) begin
         v = rnd();
         pbyte <= v[7:0];
         pulse(i);
         rchk(ADDR_RAW_EVENT, src_bit(i));
         if (i < 6) apb(1'b1, ADDR_EVENT_CLEAR, 32'hFFFF_FFFF);
         if (i == 5) rchk(ADDR_PHY_DATA, 32'(v[7:0]) << PHY_LSB);
      end
      cblk <= DATA_ONE << BIT_PHYREG;
      pulse(5);
      rchk(ADDR_RAW_EVENT, src_bit(6));
      cblk <= RESET_ZERO;
      apb(1'b1, ADDR_EVENT_CLEAR, 32'hFFFF_FFFF);
      apb(1'b1, ADDR_CONTROL, DATA_ONE << CTL_CYCLE_MASTER);
      pulse(0);
      pulse(2);
      pulse(7);
      pulse(8);
      repeat (LIM) @(posedge clk);
      rchk(ADDR_RAW_EVENT, RESET_ZERO);
      pulse(7);
      repeat (LIM) @(posedge clk);
      rchk(ADDR_RAW_EVENT, DATA_ONE << BIT_OVERRUN);
      rchk(ADDR_CONTROL, RESET_ZERO);
      `CHK(irq, 1'b1)
      apb(1'b0, 12'h0A0, RESET_ZERO);
      `CHK(er, 1'b1)
      apb(1'b1, ADDR_MASK_CLEAR, 32'hFFFF_FFFF);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      apb(1'b1, ADDR_EVENT_CLEAR, 32'hFFFF_FFFF);
      pulse(7);
      repeat (LIM) @(posedge clk);
      rchk(ADDR_RAW_EVENT, RESET_ZERO);
      $display("event test done");
      finish_test();
   end
endmodule : tb
